// [dv/self_test_result_log_bench.sv]
/*
  bench for strl_top: queue model of the log, host model drives the bus.
  assumes: 50 MHz clock, run bounded by a cycle ceiling.
*/
`timescale 1ns/10ps
`default_nettype none
module self_test_result_log_bench;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  wire [11:0] avs_address;
  wire avs_read, avs_write, avs_waitrequest, irq;
  wire [31:0] avs_writedata, avs_readdata;
  wire [3:0] avs_byteenable;
  int n_mismatch = 0, tests_run = 0, cyc = 0, i;
  logic [31:0] rd, mq[$];
  logic [3:0] m_op = 4'h0;
  logic [6:0] m_pct = 7'h00;
  always #10 core_clk = ~core_clk;
  strl_top dut (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  strl_host host (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0000_0000, rd);
    check(rd & m, e & m);
  endtask
  task op_chk;
    rdc(12'h400, m_op == 4'h0 ? 32'hFFFF_80FF : 32'hFFFF_FFFF, {17'h0, m_pct, 4'h0, m_op});
  endtask
  task log_chk;
    int k, w;
    logic [31:0] e;
    op_chk();
    for (k = 0; k < 20; k++) for (w = 0; w < 7; w++) begin
      e = (k * 7 < mq.size()) ? mq[k * 7 + w] : 32'h0000_000F;
      rdc(12'h400 + 12'(4 * (1 + 7 * k + w)), w == 0 ? 32'h0000_00FF :
        (k * 7 < mq.size() ? 32'hFFFF_FFFF : 32'h0), e);
    end
  endtask
  task start(input logic [3:0] op);
    wr(12'h000, {28'h0, op});
    if (m_op == 4'h0 && op inside {4'h1, 4'h2, 4'hE}) begin
      m_op = op;
      m_pct = 7'h00;
    end
    m_pct = m_op == 4'h0 ? m_pct : 7'($urandom % 101);
    wr(12'h004, {25'h0, m_pct});
    op_chk();
  endtask
  task commit(input logic [3:0] st);
    int w;
    logic [31:0] d[7];
    for (w = 0; w < 7; w++) begin
      d[w] = $urandom;
      wr(12'h020 + 12'(4 * w), d[w]);
    end
    wr(12'h008, {28'h0, st});
    if (m_op != 4'h0) begin
      d[0] = {24'h0, m_op, st};
      for (w = 6; w >= 0; w--) mq.push_front(d[w]);
      while (mq.size() > 140) void'(mq.pop_back());
      m_op = 4'h0;
    end
    rdc(12'h404, 32'h0000_00FF, mq.size() > 0 ? mq[0] : 32'h0000_000F);
    op_chk();
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      $display("ERROR %0t: timeout", $time);
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'h925ba132));
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    log_chk();
    start(4'h3);
    commit(4'h5);
    wr(12'h014, 32'h0000_0003);
    start(4'h1);
    start(4'h2);
    commit(4'($urandom % 16));
    @(negedge core_clk);
    check({31'h0, irq}, 32'h1);
    wr(12'h010, 32'h0000_0003);
    rdc(12'h00C, 32'h3, 32'h0);
    @(negedge core_clk);
    check({31'h0, irq}, 32'h0);
    for (i = 0; i < 21; i++) begin
      start(i % 3 == 0 ? 4'h1 : (i % 3 == 1 ? 4'h2 : 4'hE));
      commit(4'($urandom % 16));
    end
    log_chk();
    rdc(12'h00C, 32'h3, 32'h3);
    wr(12'h014, 32'h0000_0000);
    @(negedge core_clk);
    check({31'h0, irq}, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire

// [dv/strl_checker.sv]
/*
  port checker for strl_top.
  assumes: bound to strl_top, one clock, resetn low active.
*/
`timescale 1ns/10ps
`default_nettype none
module strl_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire rd_done = avs_read && !avs_waitrequest;
  wire op_rd = rd_done && avs_address == 12'h0400;
  logic [3:0] commit_age;
  // cycles since a commit write was taken; the slave is idle again from eight on
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      commit_age <= 4'hF;
    end else if (avs_write && !avs_waitrequest && avs_address == 12'h0008) begin
      commit_age <= 4'h1;
    end else if (commit_age != 4'hF) begin
      commit_age <= commit_age + 4'h1;
    end
  end
  wire slave_idle = commit_age >= 4'h8;
  read_wait_a: assert property ($rose(avs_read) && slave_idle |->
    avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest) else $error("read latency");
  write_fast_a: assert property ($rose(avs_write) && slave_idle |->
    !avs_waitrequest) else $error("write stalled when idle");
  stall_bound_a: assert property ($rose(avs_waitrequest) |-> ##[1:12] !avs_waitrequest)
    else $error("stall too long");
  sts_bits_a: assert property (rd_done && avs_address == 12'h000C |->
    avs_readdata[31:2] == 30'h0000_0000) else $error("status spare bits");
  op_reserved_a: assert property (op_rd |-> avs_readdata[31:15] == 17'h0_0000 &&
    avs_readdata[7:4] == 4'h0) else $error("reserved log bits set");
  op_code_a: assert property (op_rd |-> avs_readdata[3:0] inside {4'h0, 4'h1, 4'h2, 4'hE})
    else $error("bad operation code");
  data_hold_a: assert property ($changed(avs_readdata) |-> avs_read) else $error("readdata moved");
  irq_off_a: assert property (avs_write && !avs_waitrequest && avs_address == 12'h0014 &&
    avs_byteenable[0] && avs_writedata[1:0] == 2'h0 |=> !irq) else $error("irq while disabled");
  cover property (op_rd);
  cover property ($rose(irq));
  cover property (avs_write && !avs_waitrequest && avs_address == 12'h0008);
endmodule
bind strl_top strl_checker chk (.core_clk(core_clk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
`default_nettype wire

// [dv/strl_host.sv]
/*
  host model: avalon-mm master issuing log and control accesses.
  assumes: slave answers by dropping waitrequest.
*/
`timescale 1ns/10ps
`default_nettype none
module strl_host (
  input wire logic core_clk,
  output logic [11:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 12'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
  end
  // one transfer held until waitrequest is low at a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge core_clk); while (avs_waitrequest);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [verilog/strl_consts.vh]
/*
  constants for the self-test result log: register offsets, field
  positions, reset values, log geometry and state codes.
  assumes: included by bare name from the design files.
*/
`ifndef STRL_CONSTS_VH
`define STRL_CONSTS_VH

// log geometry
`define STRL_SLOTS 20
`define STRL_ENTRY_WORDS 7
`define STRL_MEM_WORDS 140
`define STRL_LOG_WORDS 141
`define STRL_MEM_AW 8

// register byte offsets
`define STRL_OFF_OP 12'h000
`define STRL_OFF_PCT 12'h004
`define STRL_OFF_COMMIT 12'h008
`define STRL_OFF_IRQ_STS 12'h00C
`define STRL_OFF_IRQ_CLR 12'h010
`define STRL_OFF_IRQ_EN 12'h014
`define STRL_OFF_STAGE 12'h020
`define STRL_OFF_LOG 12'h400

// current operation codes, byte 0 bits 3:0
`define STRL_OP_NONE 4'h0
`define STRL_OP_SHORT 4'h1
`define STRL_OP_EXT 4'h2
`define STRL_OP_VENDOR 4'hE

// unused entry status
`define STRL_ST_UNUSED 4'hF

// field positions
`define STRL_OP_MSB 3
`define STRL_PCT_MSB 6
`define STRL_IRQ_DONE 0
`define STRL_IRQ_WRAP 1

// reset values
`define STRL_RST_WORD 32'h0000_0000
`define STRL_RST_IRQ 2'h0

`endif

// [verilog/strl_mem.v]
/*
  result entry store: 140 words of 32 bits, one write port and one
  read port; read data come out of a register one clock after the address.
  assumes: single clock, write and read addresses below 140.
*/
`timescale 1ns/10ps
`default_nettype none
`include "strl_consts.vh"

module strl_mem (
  input wire core_clk,
  input wire wr_en,
  input wire [`STRL_MEM_AW-1:0] wr_addr,
  input wire [31:0] wr_data,
  input wire [`STRL_MEM_AW-1:0] rd_addr,
  output reg [31:0] rd_data
);

  reg [31:0] mem [0:`STRL_MEM_WORDS-1];

  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

`default_nettype wire

// [verilog/strl_top.v]
/*
  self-test result log: current operation and percent fields, twenty
  newest-first result entries, an avalon-mm slave with waitrequest for
  firmware control and for reading the log image, and one interrupt.
  assumes: one clock core_clk, asynchronous active-low resetn, a master
  that holds each request until waitrequest is low.
*/
// Operation
// - log shows running test kind and progress
// - keep results of last twenty tests
// - first slot holds newest result
// - later slots hold successively older results
// - unused slots show status Fh
// - byte 0 bits 3:0 encode operation
// - byte 0 bits 7:4 read zero
// - running op never cleared before entry
// - write entry first, then clear op
// - byte 1 bits 6:0 give percent
// - newest entry bytes 4-31, contiguous after
`timescale 1ns/10ps
`default_nettype none
`include "strl_consts.vh"

module strl_top (
  input wire core_clk,
  input wire resetn,
  input wire [11:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire irq
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RDWAIT = 4'b0010;
  localparam [3:0] ST_RDACK = 4'b0100;
  localparam [3:0] ST_COMMIT = 4'b1000;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [3:0] op_r;
  reg [6:0] pct_r;
  reg [4:0] head_r;
  reg [4:0] count_r;
  reg [2:0] wcnt_r;
  reg [3:0] res_st_r;
  reg [1:0] irq_sts_r;
  reg [1:0] irq_en_r;
  reg [31:0] stage_r [0:`STRL_ENTRY_WORDS-1];
  reg [11:0] rd_addr_r;
  reg [31:0] rdata_nxt;
  reg [`STRL_MEM_AW-1:0] mem_rd_addr;
  wire [31:0] mem_rd_data;
  wire [4:0] new_slot;
  wire [`STRL_MEM_AW-1:0] mem_wr_addr;
  wire [31:0] mem_wr_data;
  wire mem_wr_en;
  wire idle;
  wire wr_acc;
  wire rd_acc;
  wire commit_done;
  wire commit_go;
  wire [1:0] irq_set;
  wire [1:0] irq_clr;
  wire [9:0] log_word;
  wire [9:0] log_entry_off;
  wire [2:0] log_wsel;
  wire [9:0] bus_entry_off;
  wire rd_wait;
  wire wr_wait;
  integer i;

  // merge write data into a word under byte enables
  function [31:0] be_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] be;
    integer b;
    begin
      be_merge = old_val;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b]) begin
          be_merge[b*8 +: 8] = new_val[b*8 +: 8];
        end
      end
    end
  endfunction

  // memory word address of one word within one slot
  function [`STRL_MEM_AW-1:0] slot_addr;
    input [4:0] slot;
    input [2:0] wsel;
    reg [9:0] full;
    begin
      full = {5'h00, slot} * 10'd7 + {7'h00, wsel};
      slot_addr = full[`STRL_MEM_AW-1:0];
    end
  endfunction

  // physical slot of the entry that is age positions older than head
  function [4:0] age_slot;
    input [4:0] head;
    input [4:0] age;
    begin
      if (age > head) begin
        age_slot = head + 5'd20 - age;
      end else begin
        age_slot = head - age;
      end
    end
  endfunction

  // next slot after the newest, wrapping at the slot count
  function [4:0] slot_inc;
    input [4:0] slot;
    begin
      if (slot == 5'd19) begin
        slot_inc = 5'd0;
      end else begin
        slot_inc = slot + 5'd1;
      end
    end
  endfunction

  // address falls on one of the seven staging words
  function is_stage;
    input [11:0] addr;
    begin
      is_stage = (addr >= `STRL_OFF_STAGE) && (addr < `STRL_OFF_STAGE + 12'h01C);
    end
  endfunction

  // address falls in the log image window
  function is_log;
    input [11:0] addr;
    begin
      is_log = (addr >= `STRL_OFF_LOG);
    end
  endfunction

  // age (slot index in newest-first order) of a log entry word
  function [4:0] entry_age;
    input [9:0] off;
    reg [9:0] q;
    begin
      q = off / 10'd7;
      entry_age = q[4:0];
    end
  endfunction

  // word position inside an entry
  function [2:0] entry_wsel;
    input [9:0] off;
    reg [9:0] r;
    begin
      r = off % 10'd7;
      entry_wsel = r[2:0];
    end
  endfunction

  assign idle = (state_r == ST_IDLE);
  assign wr_acc = idle & avs_write & ~avs_read;
  assign rd_acc = idle & avs_read & ~avs_write;
  // reads stall until the answer stage; writes stall only while busy
  assign rd_wait = (state_r != ST_RDACK);
  assign wr_wait = ~idle;
  assign avs_waitrequest = avs_read ? rd_wait : (avs_write ? wr_wait : 1'b0);

  // a result may only be recorded while a test is running
  assign commit_go = wr_acc & (avs_address == `STRL_OFF_COMMIT) & avs_byteenable[0] &
                     (op_r != `STRL_OP_NONE);
  assign commit_done = (state_r == ST_COMMIT) & (wcnt_r == 3'd6);

  // new entry goes one slot past the newest; when full this overwrites the oldest
  assign new_slot = (count_r == 5'd0) ? head_r : slot_inc(head_r);
  assign mem_wr_en = (state_r == ST_COMMIT);
  assign mem_wr_addr = slot_addr(new_slot, wcnt_r);
  // byte 0 of an entry: test code above, result status below
  assign mem_wr_data = (wcnt_r == 3'd0) ? {stage_r[0][31:8], op_r, res_st_r} :
                       stage_r[wcnt_r];

  // log image: word 0 is the header, then seven words per entry, newest first
  assign log_word = rd_addr_r[11:2] - 10'd256;
  assign log_entry_off = log_word - 10'd1;
  assign log_wsel = entry_wsel(log_entry_off);
  assign bus_entry_off = avs_address[11:2] - 10'd257;

  // memory address of the entry word on the bus, parked at zero elsewhere
  always @* begin
    mem_rd_addr = {`STRL_MEM_AW{1'b0}};
    if (is_log(avs_address) && bus_entry_off < `STRL_MEM_WORDS) begin
      mem_rd_addr = slot_addr(age_slot(head_r, entry_age(bus_entry_off)),
                              entry_wsel(bus_entry_off));
    end
  end

  strl_mem u_mem (
    .core_clk(core_clk),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (rd_acc) begin
          state_nxt = ST_RDWAIT;
        end else if (commit_go) begin
          state_nxt = ST_COMMIT;
        end
      end
      ST_RDWAIT: begin
        state_nxt = ST_RDACK;
      end
      ST_RDACK: begin
        state_nxt = ST_IDLE;
      end
      ST_COMMIT: begin
        if (commit_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // read data mux, formed while the memory word settles
  always @* begin
    rdata_nxt = `STRL_RST_WORD;
    if (is_log(rd_addr_r)) begin
      if (log_word == 10'd0) begin
        rdata_nxt = {16'h0000, 1'b0, pct_r, 4'h0, op_r};
      end else if (log_word < `STRL_LOG_WORDS) begin
        if (entry_age(log_entry_off) >= count_r) begin
          rdata_nxt = (log_wsel == 3'd0) ? {28'h0000_000, `STRL_ST_UNUSED} :
                      `STRL_RST_WORD;
        end else begin
          rdata_nxt = mem_rd_data;
        end
      end
    end else begin
      case (rd_addr_r)
        `STRL_OFF_OP: rdata_nxt = {28'h0000_000, op_r};
        `STRL_OFF_PCT: rdata_nxt = {25'h000_0000, pct_r};
        `STRL_OFF_COMMIT: rdata_nxt = {27'h000_0000, count_r};
        `STRL_OFF_IRQ_STS: rdata_nxt = {30'h0000_0000, irq_sts_r};
        `STRL_OFF_IRQ_EN: rdata_nxt = {30'h0000_0000, irq_en_r};
        default: begin
          if (is_stage(rd_addr_r)) begin
            rdata_nxt = stage_r[rd_addr_r[4:2]];
          end
        end
      endcase
    end
  end

  // events: entry recorded, and oldest entry dropped
  assign irq_set = {commit_done & (count_r == 5'd20), commit_done};
  assign irq_clr = (wr_acc && avs_address == `STRL_OFF_IRQ_CLR && avs_byteenable[0]) ?
                   avs_writedata[1:0] : 2'b00;
  assign irq = |(irq_sts_r & irq_en_r);

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      op_r <= `STRL_OP_NONE;
      pct_r <= 7'h00;
      head_r <= 5'h00;
      count_r <= 5'h00;
      wcnt_r <= 3'h0;
      res_st_r <= 4'h0;
      irq_sts_r <= `STRL_RST_IRQ;
      irq_en_r <= `STRL_RST_IRQ;
      rd_addr_r <= 12'h000;
      avs_readdata <= `STRL_RST_WORD;
      for (i = 0; i < `STRL_ENTRY_WORDS; i = i + 1) begin
        stage_r[i] <= `STRL_RST_WORD;
      end
    end else begin
      state_r <= state_nxt;
      irq_sts_r <= (irq_sts_r & ~irq_clr) | irq_set;
      if (rd_acc) begin
        rd_addr_r <= avs_address;
      end
      if (state_r == ST_RDWAIT) begin
        avs_readdata <= rdata_nxt;
      end
      if (wr_acc) begin
        case (avs_address)
          `STRL_OFF_OP: begin
            // a new test starts only when none is running
            if (avs_byteenable[0] && op_r == `STRL_OP_NONE &&
                (avs_writedata[3:0] == `STRL_OP_SHORT || avs_writedata[3:0] == `STRL_OP_EXT ||
                 avs_writedata[3:0] == `STRL_OP_VENDOR)) begin
              op_r <= avs_writedata[3:0];
              pct_r <= 7'h00;
            end
          end
          `STRL_OFF_PCT: begin
            if (avs_byteenable[0] && op_r != `STRL_OP_NONE) begin
              pct_r <= avs_writedata[6:0];
            end
          end
          `STRL_OFF_IRQ_EN: begin
            if (avs_byteenable[0]) begin
              irq_en_r <= avs_writedata[1:0];
            end
          end
          default: begin
            if (is_stage(avs_address)) begin
              stage_r[avs_address[4:2]] <= be_merge(stage_r[avs_address[4:2]],
                                                    avs_writedata, avs_byteenable);
            end
          end
        endcase
      end
      if (commit_go) begin
        res_st_r <= avs_writedata[3:0];
        wcnt_r <= 3'h0;
      end else if (state_r == ST_COMMIT && !commit_done) begin
        wcnt_r <= wcnt_r + 3'h1;
      end
      // last entry word written on the same edge that returns the operation to idle
      if (commit_done) begin
        head_r <= new_slot;
        if (count_r != 5'd20) begin
          count_r <= count_r + 5'd1;
        end
        op_r <= `STRL_OP_NONE;
      end
    end
  end

endmodule

`default_nettype wire
